// ==== pcmsf_pkg.sv ====
// Package for the connection status block: register map, field positions, codes, timing.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register bus.
package pcmsf_pkg;
	localparam logic [7:0]  ADDR_STATUS_B   = 8'h00; // connection_status_b, read only.
	localparam logic [7:0]  ADDR_XMIT_VEC   = 8'h04; // transmit_bit_vector.
	localparam logic [7:0]  ADDR_SIG_COUNT  = 8'h08; // signal_bit_count.
	localparam logic [7:0]  ADDR_CONTROL    = 8'h0C; // Write 1 to bit 0 clears the signaling flag.
	localparam logic [7:0]  ADDR_TIMERS     = 8'h10; // Phase timer low half, noise timer high half.
	localparam int          BIT_SIGNALING   = 6;
	localparam int          BIT_LSF         = 5;
	localparam int          BIT_RCF         = 4;
	localparam int          BIT_TCF         = 3;
	localparam logic [2:0]  CAUSE_NONE      = 3'h0;
	localparam logic [2:0]  CAUSE_START     = 3'h1;
	localparam logic [2:0]  CAUSE_TOUT      = 3'h2;
	localparam logic [2:0]  CAUSE_NOISE     = 3'h3;
	localparam logic [2:0]  CAUSE_QUIET     = 3'h4;
	localparam logic [2:0]  CAUSE_IDLE      = 3'h5;
	localparam logic [2:0]  CAUSE_HALT      = 3'h6;
	localparam int          PHASE_DIV_BITS  = 8;
	localparam int          NOISE_DIV_BITS  = 2;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [15:0] RESET_ZERO16    = 16'h0000;

	// Break cause event inputs, grouped.
	typedef struct packed {
		logic start;  // Begin command issued.
		logic quiet;  // Quiet line state seen.
		logic idle;   // Idle line state seen.
		logic halt;   // Halt line state seen.
	} pcmsf_brk_s;
endpackage

// ==== pcmsf_top.sv ====
// Connection manager status flags, break cause capture and two prescaled timers.
// Assumes all event inputs come from same-clock logic and AXI4-Lite master on clk.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - Vector write sets signaling flag bit 6
// - Vector and length writes blocked while signaling
// - Line state seen flag clears on state change
// - Receive code flag set when routine starts
// - Transmit code flag set when routine starts
// - Three-bit break cause in bits 2..0
// - Cause 0 never, 1 begin command
// - Cause 2 phase timer timeout expiry
// - Cause 3 noise timer expiry
// - Cause 4 quiet line state
// - Cause 5 idle line state
// - Cause 6 halt state; 7 never
// - Exactly two timers: phase and noise
// - Each timer advanced through own divider
// - Phase timer advances every 256 clocks
// - Noise timer advances every 4 clocks
// - Phase timeout while awaiting response breaks
// - Noise expiry before idle breaks
module pcmsf_top
	import pcmsf_pkg::*;
(
	input  wire logic              clk,            // 10 MHz clock.
	input  wire logic              rst,            // Async reset, active high.
	input  wire logic [7:0]        s_axi_awaddr,   // Write address.
	input  wire logic              s_axi_awvalid,  // Write address valid.
	output logic                   s_axi_awready,  // Write address ready.
	input  wire logic [31:0]       s_axi_wdata,    // Write data.
	input  wire logic [3:0]        s_axi_wstrb,    // Write strobes.
	input  wire logic              s_axi_wvalid,   // Write data valid.
	output logic                   s_axi_wready,   // Write data ready.
	output logic [1:0]             s_axi_bresp,    // Write response.
	output logic                   s_axi_bvalid,   // Write response valid.
	input  wire logic              s_axi_bready,   // Write response ready.
	input  wire logic [7:0]        s_axi_araddr,   // Read address.
	input  wire logic              s_axi_arvalid,  // Read address valid.
	output logic                   s_axi_arready,  // Read address ready.
	output logic [31:0]            s_axi_rdata,    // Read data.
	output logic [1:0]             s_axi_rresp,    // Read response.
	output logic                   s_axi_rvalid,   // Read data valid.
	input  wire logic              s_axi_rready,   // Read data ready.
	input  wire logic [3:0]        conn_state,     // Connection manager state code.
	input  wire logic              line_state_hit, // Awaited line state recognised.
	input  wire logic              rx_code_start,  // Receive routine begins.
	input  wire logic              tx_code_start,  // Transmit routine begins.
	input  wire logic              signal_done,    // Signaling exchange finished.
	input  pcmsf_pkg::pcmsf_brk_s  brk_evt,        // Line-state and command break causes.
	input  wire logic              phase_load,     // Load phase timer.
	input  wire logic [15:0]       phase_load_val, // Two's complement load value.
	input  wire logic              phase_resp_wait,// Response expected from neighbour.
	input  wire logic              noise_load,     // Load noise timer (left idle).
	input  wire logic [15:0]       noise_limit_time,// Two's complement noise limit.
	input  wire logic              noise_idle_seen,// Idle line state recognised again.
	output logic                   break_req,      // One-cycle request to enter break.
	output logic [15:0]            transmit_bit_vector, // Stored vector.
	output logic [3:0]             signal_bit_count     // Stored length.
);
	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] connection_phase_timer;
	logic [15:0] noise_event_timer;
	logic [7:0]  phase_div;
	logic [1:0]  noise_div;
	logic        phase_run;
	logic        noise_run;
	logic        phase_exp;
	logic        noise_exp;
	logic        signaling;
	logic        line_state_seen_flag;
	logic        rx_code_started_flag;
	logic        tx_code_started_flag;
	logic [2:0]  cause;
	logic [3:0]  state_q;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        wr_fire;
	logic        vec_write_ok;
	logic        cnt_write_ok;
	logic        clear_write;

	// Returns true when a divider at full count carries into its timer.
	function automatic logic div_carry(input logic [7:0] div, input logic [7:0] top);
		return div == top;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Phase timer with 8-bit prescaler; the divider restarts at zero on every load.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_div              <= 8'h00;
			connection_phase_timer <= 16'h0000;
			phase_run              <= 1'b0;
		end else if (phase_load) begin
			phase_div              <= 8'h00;
			connection_phase_timer <= phase_load_val;
			phase_run              <= 1'b1;
		end else if (phase_run) begin
			phase_div <= phase_div + 8'h01;
			if (div_carry(phase_div, 8'hFF)) begin
				connection_phase_timer <= connection_phase_timer + 16'h0001;
				if (connection_phase_timer == 16'hFFFF) begin
					phase_run <= 1'b0;
				end
			end
		end
	end
	assign phase_exp = phase_run && div_carry(phase_div, 8'hFF)
		&& connection_phase_timer == 16'hFFFF;

	// Noise timer with 2-bit prescaler, loaded when the line leaves idle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			noise_div         <= 2'h0;
			noise_event_timer <= 16'h0000;
			noise_run         <= 1'b0;
		end else if (noise_load) begin
			noise_div         <= 2'h0;
			noise_event_timer <= noise_limit_time;
			noise_run         <= 1'b1;
		end else if (noise_idle_seen) begin
			noise_run <= 1'b0; // Idle came back in time, no break.
		end else if (noise_run) begin
			noise_div <= noise_div + 2'h1;
			if (div_carry({6'h00, noise_div}, 8'h03)) begin
				noise_event_timer <= noise_event_timer + 16'h0001;
				if (noise_event_timer == 16'hFFFF) begin
					noise_run <= 1'b0;
				end
			end
		end
	end
	assign noise_exp = noise_run && !noise_load && !noise_idle_seen
		&& div_carry({6'h00, noise_div}, 8'h03) && noise_event_timer == 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////////
	// Break cause capture; start command has top priority, then timers, then line states.
	assign break_req = brk_evt.start || (phase_exp && phase_resp_wait) || noise_exp
		|| brk_evt.quiet || brk_evt.idle || brk_evt.halt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cause <= CAUSE_NONE;
		end else if (brk_evt.start) begin
			cause <= CAUSE_START;
		end else if (phase_exp && phase_resp_wait) begin
			cause <= CAUSE_TOUT;
		end else if (noise_exp) begin
			cause <= CAUSE_NOISE;
		end else if (brk_evt.quiet) begin
			cause <= CAUSE_QUIET;
		end else if (brk_evt.idle) begin
			cause <= CAUSE_IDLE;
		end else if (brk_evt.halt) begin
			cause <= CAUSE_HALT;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags; a new state clears the line flag unless a hit lands the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= 4'h0;
			line_state_seen_flag     <= 1'b0;
			rx_code_started_flag     <= 1'b0;
			tx_code_started_flag     <= 1'b0;
		end else begin
			state_q <= conn_state;
			if (line_state_hit) begin
				line_state_seen_flag <= 1'b1;
			end else if (conn_state != state_q) begin
				line_state_seen_flag <= 1'b0;
			end
			if (rx_code_start) begin
				rx_code_started_flag <= 1'b1;
			end else if (conn_state != state_q) begin
				rx_code_started_flag <= 1'b0;
			end
			if (tx_code_start) begin
				tx_code_started_flag <= 1'b1;
			end else if (conn_state != state_q) begin
				tx_code_started_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order, response follows both.
	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = !w_got && !s_axi_bvalid;
	assign wr_fire       = aw_got && w_got && !s_axi_bvalid;
	assign vec_write_ok  = wr_fire && aw_q == ADDR_XMIT_VEC && !signaling;
	assign cnt_write_ok  = wr_fire && aw_q == ADDR_SIG_COUNT && !signaling;
	assign clear_write   = wr_fire && aw_q == ADDR_CONTROL && ws_q[0] && w_q[0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_got       <= 1'b0;
			w_got        <= 1'b0;
			aw_q         <= 8'h00;
			w_q          <= 32'h0000_0000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_q   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_q   <= s_axi_wdata;
				ws_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_q == ADDR_XMIT_VEC || aw_q == ADDR_SIG_COUNT || aw_q == ADDR_CONTROL) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Vector registers and signaling flag; a finished exchange unlocks the vectors.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			transmit_bit_vector <= RESET_ZERO16;
			signal_bit_count    <= 4'h0;
			signaling           <= 1'b0;
		end else begin
			if (vec_write_ok) begin
				if (ws_q[0]) transmit_bit_vector[7:0] <= w_q[7:0];
				if (ws_q[1]) transmit_bit_vector[15:8] <= w_q[15:8];
				signaling <= 1'b1;
			end else if (signal_done || clear_write) begin
				signaling <= 1'b0;
			end
			if (cnt_write_ok && ws_q[0]) begin
				signal_bit_count <= w_q[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel, one cycle answer; unmapped addresses answer SLVERR with zero data.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			if (s_axi_araddr == ADDR_STATUS_B) begin
				s_axi_rdata <= {16'h0000, 5'h00, conn_state, signaling, line_state_seen_flag, rx_code_started_flag, tx_code_started_flag, cause};
			end else if (s_axi_araddr == ADDR_XMIT_VEC) begin
				s_axi_rdata <= {16'h0000, transmit_bit_vector};
			end else if (s_axi_araddr == ADDR_SIG_COUNT) begin
				s_axi_rdata <= {28'h0000000, signal_bit_count};
			end else if (s_axi_araddr == ADDR_CONTROL) begin
				s_axi_rdata <= 32'h0000_0000;
			end else if (s_axi_araddr == ADDR_TIMERS) begin
				s_axi_rdata <= {noise_event_timer, connection_phase_timer};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks kept beside the logic.
	sequence vec_write_seq;
		vec_write_ok;
	endsequence

	AST_SIG_SET: assert property (@(posedge clk) disable iff (rst)
		vec_write_seq |=> signaling) else $error("signaling flag not set after vector write");
	AST_VEC_LOCK: assert property (@(posedge clk) disable iff (rst)
		(signaling && !vec_write_ok) |=> $stable(transmit_bit_vector))
		else $error("vector changed while locked");
	AST_LSF_CLR: assert property (@(posedge clk) disable iff (rst)
		(conn_state != state_q && !line_state_hit) |=> !line_state_seen_flag) else $error("lsf not cleared");
	AST_RCF_SET: assert property (@(posedge clk) disable iff (rst)
		rx_code_start |=> rx_code_started_flag) else $error("rcf not set");
	AST_TCF_SET: assert property (@(posedge clk) disable iff (rst)
		tx_code_start |=> tx_code_started_flag) else $error("tcf not set");
	AST_START_CAUSE: assert property (@(posedge clk) disable iff (rst)
		brk_evt.start |=> cause == CAUSE_START) else $error("start cause wrong");
	AST_NO_111: assert property (@(posedge clk) disable iff (rst)
		cause != 3'h7) else $error("reserved cause produced");
	AST_CAUSE_HOLD: assert property (@(posedge clk) disable iff (rst)
		!break_req |=> $stable(cause)) else $error("cause changed without break");
	// Four running clocks from a fresh divider; the step shows one edge after the last.
	sequence noise_period_seq;
		(noise_run && !noise_load && !noise_idle_seen && noise_div == 2'h0) ##1
		(noise_run && !noise_load && !noise_idle_seen)[*3];
	endsequence

	AST_NOISE_DIV: assert property (@(posedge clk) disable iff (rst)
		noise_period_seq |=> noise_event_timer == $past(noise_event_timer, 4) + 16'h0001)
		else $error("noise timer step wrong");
endmodule // pcmsf_top

// ==== pcmsf_neighbor.sv ====
// Neighbour model: turns a bench command into one-cycle line and code events.
// Assumes commands arrive as a one-cycle strobe on the shared clock.
`timescale 1ns/100ps
module pcmsf_neighbor
	import pcmsf_pkg::*;
(
	input  wire logic             clk,      // Shared clock.
	input  wire logic             rst,      // Async reset, active high.
	input  wire logic             go,       // Command strobe.
	input  wire logic [2:0]       kind,     // Event selector.
	output pcmsf_pkg::pcmsf_brk_s brk_evt,  // Break cause pulses.
	output logic                  hit,      // Awaited line state seen.
	output logic                  rx_start, // Receive routine begins.
	output logic                  tx_start  // Transmit routine begins.
);
	////////////////////////////////////////////////////////////////////////////////
	// Every event lasts exactly one cycle, as a real neighbour would give it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brk_evt  <= '0;
			hit      <= 1'h0;
			rx_start <= 1'h0;
			tx_start <= 1'h0;
		end else begin
			brk_evt.start <= go && kind == 3'h0;
			brk_evt.quiet <= go && kind == 3'h1;
			brk_evt.idle  <= go && kind == 3'h2;
			brk_evt.halt  <= go && kind == 3'h3;
			hit           <= go && kind == 3'h4;
			rx_start      <= go && kind == 3'h5;
			tx_start      <= go && kind == 3'h6;
		end
	end
endmodule // pcmsf_neighbor

// ==== tb.sv ====
// Self-checking bench for the connection status block.
// Assumes the neighbour model supplies line and code events on the same clock.
`timescale 1ns/100ps
module tb;
	import pcmsf_pkg::*;
	logic        clk, rst, go, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, brk, hit, rxs, txs;
	logic        done, pload, pwait, nload, nidle;
	logic [2:0]  kind;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, resp;
	logic [3:0]  cstate, cnt;
	logic [15:0] pval, nval, vec;
	pcmsf_brk_s  evt;
	int          n_errors, check_count;

	pcmsf_top uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.conn_state(cstate), .line_state_hit(hit), .rx_code_start(rxs), .tx_code_start(txs),
		.signal_done(done), .brk_evt(evt), .phase_load(pload), .phase_load_val(pval),
		.phase_resp_wait(pwait), .noise_load(nload), .noise_limit_time(nval),
		.noise_idle_seen(nidle), .break_req(brk), .transmit_bit_vector(vec),
		.signal_bit_count(cnt));
	pcmsf_neighbor nbr (.clk(clk), .rst(rst), .go(go), .kind(kind), .brk_evt(evt),
		.hit(hit), .rx_start(rxs), .tx_start(txs));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running 10 MHz clock.
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Verdict; the only place the run ends.
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compares one value; case inequality so an unknown never matches.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// A bounded wait ran out: count it and stop.
	task automatic tmo;
		n_errors++;
		$display("mismatch bus_wait expected answer seen none");
		tally_and_finish();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// AXI write: address and data offered together, each dropped once taken.
	// Handshakes are judged on settled values at the falling edge, which equal what
	// the slave samples at the next rising edge; reading them at the edge would race.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		n = 0;
		b_ok = 1'h0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		while (!b_ok && n < 50) begin
			@(negedge clk);
			aw_ok = (awvalid && awready) === 1'h1;
			w_ok  = (wvalid && wready) === 1'h1;
			b_ok  = bvalid === 1'h1;
			resp  = bresp;
			@(posedge clk);
			n++;
			if (aw_ok) awvalid <= 1'h0;
			if (w_ok) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		if (!b_ok) tmo();
	endtask

	// AXI read: data and response taken at the edge where rvalid is sampled.
	task automatic rdr(input logic [7:0] a);
		int   n;
		logic ar_ok;
		logic r_ok;
		n = 0;
		r_ok = 1'h0;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		while (!r_ok && n < 50) begin
			@(negedge clk);
			ar_ok = (arvalid && arready) === 1'h1;
			r_ok  = rvalid === 1'h1;
			rd    = rdata;
			resp  = rresp;
			@(posedge clk);
			n++;
			if (ar_ok) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		if (!r_ok) tmo();
	endtask

	// Asks the neighbour for one event, then lets it settle.
	task automatic ev(input logic [2:0] k);
		@(posedge clk);
		kind <= k;
		go   <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		repeat (3) @(posedge clk);
	endtask

	// Counts settled samples until a break request, giving up at the limit.
	// The break request is combinational, so it is looked at mid-cycle, then the
	// task realigns to a rising edge so later stimulus stays on the rising edge.
	task automatic wbrk(input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (brk !== 1'h1 && n < lim);
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset state and an unmapped address.
	task automatic t_reset;
		rdr(ADDR_STATUS_B);
		chk("status_reset", 32'h0, rd);
		rdr(8'h20);
		chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		chk("unmapped_data", 32'h0, rd);
	endtask

	// Vector write raises signaling and locks both vector registers.
	task automatic t_signal;
		wr(ADDR_XMIT_VEC, 32'h0000A5C3);
		rdr(ADDR_STATUS_B);
		chk("signaling", 32'h40, rd & 32'h40);
		chk("vector", 32'hA5C3, {16'h0, vec});
		wr(ADDR_XMIT_VEC, 32'h00001234);
		chk("locked_resp", {30'h0, RESP_OKAY}, {30'h0, resp});
		wr(ADDR_SIG_COUNT, 32'h5);
		chk("vector_locked", 32'hA5C3, {16'h0, vec});
		chk("count_locked", 32'h0, {28'h0, cnt});
		wr(ADDR_CONTROL, 32'h1);
		rdr(ADDR_STATUS_B);
		chk("signaling_clr", 32'h0, rd & 32'h40);
		wr(ADDR_SIG_COUNT, 32'h9);
		chk("count", 32'h9, {28'h0, cnt});
		wr(ADDR_XMIT_VEC, 32'h00000000);
		@(posedge clk);
		done <= 1'h1;
		@(posedge clk);
		done <= 1'h0;
		rdr(ADDR_STATUS_B);
		chk("signaling_done", 32'h0, rd & 32'h40);
		wr(ADDR_STATUS_B, 32'h0);
		chk("ro_resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
	endtask

	// Code and line flags set by events, all cleared by a state change.
	task automatic t_flags;
		cstate <= 4'h4;
		ev(3'h4);
		ev(3'h5);
		ev(3'h6);
		rdr(ADDR_STATUS_B);
		chk("flags_set", 32'h238, rd);
		cstate <= 4'h5;
		ev(3'h7);
		rdr(ADDR_STATUS_B);
		chk("flags_clr", 32'h280, rd);
	endtask

	// Each line-state and command cause in turn, then a hold across a state change.
	task automatic t_causes;
		logic [2:0] tab [4];
		tab = '{CAUSE_START, CAUSE_QUIET, CAUSE_IDLE, CAUSE_HALT};
		for (int k = 0; k < 4; k++) begin
			ev(3'(k));
			rdr(ADDR_STATUS_B);
			chk("cause", {29'h0, tab[k]}, rd & 32'h7);
		end
		cstate <= 4'h3;
		ev(3'h7);
		rdr(ADDR_STATUS_B);
		chk("cause_hold", {29'h0, CAUSE_HALT}, rd & 32'h7);
	endtask

	// Phase timer one step from expiry: break after one 256-clock divider period.
	task automatic t_phase;
		int n;
		@(posedge clk);
		pwait <= 1'h1;
		pval  <= 16'hFFFF;
		pload <= 1'h1;
		@(posedge clk);
		pload <= 1'h0;
		wbrk(400, n);
		chk("phase_period", 32'h1, 32'(n >= 252 && n <= 260));
		pwait <= 1'h0;
		rdr(ADDR_STATUS_B);
		chk("cause_tout", {29'h0, CAUSE_TOUT}, rd & 32'h7);
	endtask

	// Noise timer: idle seen stops it, otherwise expiry after four clocks.
	task automatic t_noise;
		int n;
		@(posedge clk);
		nval  <= 16'hFFFE;
		nload <= 1'h1;
		nidle <= 1'h1;
		@(posedge clk);
		nload <= 1'h0;
		wbrk(40, n);
		chk("noise_stopped", 32'h28, 32'(n));
		nidle <= 1'h0;
		nval  <= 16'hFFFF;
		nload <= 1'h1;
		@(posedge clk);
		nload <= 1'h0;
		wbrk(40, n);
		chk("noise_period", 32'h1, 32'(n >= 2 && n <= 6));
		rdr(ADDR_STATUS_B);
		chk("cause_noise", {29'h0, CAUSE_NOISE}, rd & 32'h7);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset held for 20 clocks, then each scenario in turn.
	initial begin
		{rst, go, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		{done, pload, pwait, nload, nidle} = 5'h0;
		{kind, awaddr, araddr, wdata, cstate, pval, nval} = '0;
		n_errors = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_signal();
		t_flags();
		t_causes();
		t_phase();
		t_noise();
		tally_and_finish();
	end
endmodule // tb
